/* File: common/dsc_pkg.sv */
// dsc_pkg: shared constants of the dds serial and select control block
package dsc_pkg;

  // ----------------------------------------------------------------
  // datapath widths
  // ----------------------------------------------------------------
  localparam int ACC_W = 32;
  localparam int PHASE_W = 12;
  localparam int WORD_W = 16;
  localparam int NUM_PHASE = 4;
  localparam int AXI_AW = 6;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_STEP_A = 6'h04;
  localparam logic [5:0] OFF_STEP_B = 6'h08;
  localparam logic [5:0] OFF_PHASE0 = 6'h0c;
  localparam logic [5:0] OFF_STATUS = 6'h1c;
  localparam logic [5:0] OFF_ACC = 6'h20;

  // ----------------------------------------------------------------
  // control field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_W = 4;
  localparam int CTRL_FREQ_BIT = 0;
  localparam int CTRL_PHASE_LSB = 1;
  localparam int CTRL_USE_BITS = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [31:0] STEP_RESET = 32'h0000_0000;
  localparam logic [11:0] PHASE_RESET = 12'h000;

  // ----------------------------------------------------------------
  // serial command word layout
  // ----------------------------------------------------------------
  localparam int WORD_CMD_LSB = 12;
  localparam int WORD_IDX_LSB = 8;
  localparam logic [3:0] CMD_STEP_BYTE = 4'h0;
  localparam logic [1:0] CMD_PHASE_TOP = 2'h1;
  localparam logic [3:0] CMD_CTRL = 4'h8;

  // ----------------------------------------------------------------
  // bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : dsc_pkg

/* File: verification/dsc_ctrl_bench.sv */
// dsc_ctrl_bench: self-checking bench of the dds serial and select control block
module dsc_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic fsel = 1'b0;
  logic [1:0] psel = 2'h0;
  logic [5:0] aw = 6'h00;
  logic [5:0] ar = 6'h00;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic bready = 1'b0;
  logic arv = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wd = 32'h0000_0000;
  logic [3:0] ws = 4'hf;
  logic shift_clk, word_frame_n, serial_in, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d, e;
  logic [11:0] phase_out, p0, p1;
  logic [11:0] off [4];
  logic [15:0] w;
  int errors = 0;
  int cmp_count = 0;

  // 50 mhz master clock
  always #10 clk = ~clk;

  dsc_host u_host (.shift_clk(shift_clk), .word_frame_n(word_frame_n), .serial_in(serial_in));

  dsc_ctrl dut (.clk(clk), .rst(rst), .shift_clk(shift_clk), .word_frame_n(word_frame_n),
    .serial_in(serial_in), .freq_reg_choose(fsel), .phase_reg_choose_lsb(psel[0]),
    .phase_reg_choose_msb(psel[1]), .phase_out(phase_out), .s_axi_awaddr(aw),
    .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // one axi4-lite write or read; answer lands in d and r
  task automatic axi(input logic wr, input logic [5:0] a, input logic [31:0] v,
      input logic [3:0] s);
    logic got;
    got = 1'b0;
    @(posedge clk);
    aw <= a;
    ar <= a;
    wd <= v;
    ws <= s;
    awv <= wr;
    wv <= wr;
    bready <= wr;
    arv <= !wr;
    rready <= !wr;
    for (int n = 0; n < 300 && !got; n++) begin
      @(posedge clk);
      if (awready === 1'b1) awv <= 1'b0;
      if (wready === 1'b1) wv <= 1'b0;
      if (arready === 1'b1) arv <= 1'b0;
      got = wr ? bvalid === 1'b1 : rvalid === 1'b1;
    end
    d = rdata;
    r = wr ? bresp : rresp;
    bready <= 1'b0;
    rready <= 1'b0;
    if (!got) begin
      errors++;
      print_verdict();
    end
  endtask : axi

  // let selections settle, then take two consecutive outputs
  task automatic settle();
    repeat (8) @(posedge clk);
    @(negedge clk);
    p0 = phase_out;
    @(negedge clk);
    p1 = phase_out;
  endtask : settle

  // walk all four offsets by pins or by serial control words, zero step held
  task automatic scan(input logic by_bits);
    logic [11:0] base;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      if (by_bits) u_host.send(16'h8009 | 16'(i << 1), 16);
      else psel <= 2'(i);
      settle();
      check("held phase", 32'(12'(p1 - p0)), 32'h0);
      if (i == 0) base = p1;
      check("phase offset", 32'(p1), 32'(12'(base + off[i] - off[0])));
    end
  endtask : scan

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hfa603a2e));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    axi(1'b0, dsc_pkg::OFF_STEP_A, 32'h0, 4'hf);
    check("step a reset", d, dsc_pkg::STEP_RESET);
    axi(1'b0, dsc_pkg::OFF_CTRL, 32'h0, 4'hf);
    check("ctrl reset", d, 32'(dsc_pkg::CTRL_RESET));
    axi(1'b0, 6'h3c, 32'h0, 4'hf);
    check("unmapped data", d, 32'h0);
    check("unmapped read", 32'(r), 32'(dsc_pkg::RESP_SLVERR));
    axi(1'b1, 6'h3c, 32'h1, 4'hf);
    check("unmapped write", 32'(r), 32'(dsc_pkg::RESP_SLVERR));
    axi(1'b1, dsc_pkg::OFF_STEP_B, 32'hffff_ffff, 4'h4);
    check("write resp", 32'(r), 32'(dsc_pkg::RESP_OKAY));
    axi(1'b0, dsc_pkg::OFF_STEP_B, 32'h0, 4'hf);
    check("strobed write", d, 32'h00ff_0000);
    axi(1'b1, dsc_pkg::OFF_STEP_B, 32'h0, 4'hf);
    e = {12'($urandom) | 12'h001, 20'h0};
    axi(1'b1, dsc_pkg::OFF_STEP_A, e, 4'hf);
    for (int i = 0; i < 4; i++) begin
      off[i] = (i == 3) ? 12'hfff : 12'($urandom);
      axi(1'b1, dsc_pkg::OFF_PHASE0 + 6'(4 * i), 32'(off[i]), 4'hf);
      axi(1'b0, dsc_pkg::OFF_PHASE0 + 6'(4 * i), 32'h0, 4'hf);
      check("offset read", d, 32'(off[i]));
    end
    settle();
    check("step a delta", 32'(12'(p1 - p0)), 32'(e[31:20]));
    @(posedge clk);
    fsel <= 1'b1;
    scan(1'b0);
    @(posedge clk);
    fsel <= 1'b0;
    psel <= 2'h0;
    scan(1'b1);
    axi(1'b1, dsc_pkg::OFF_CTRL, 32'h0, 4'hf);
    settle();
    check("pins again", 32'(12'(p1 - p0)), 32'(e[31:20]));
    w = {4'h7, 12'($urandom)};
    u_host.send(w, 16);
    settle();
    axi(1'b0, dsc_pkg::OFF_PHASE0 + 6'h0c, 32'h0, 4'hf);
    check("serial offset", d, 32'(w[11:0]));
    for (int i = 4; i < 8; i++) begin
      w = {5'h0, 3'(i), 8'($urandom)};
      e[8 * (i - 4) +: 8] = w[7:0];
      u_host.send(w, 16);
    end
    settle();
    axi(1'b0, dsc_pkg::OFF_STEP_B, 32'h0, 4'hf);
    check("serial step b", d, e);
    axi(1'b0, dsc_pkg::OFF_STATUS, 32'h0, 4'hf);
    check("last word", 32'(d[15:0]), 32'(w));
    u_host.send(16'h8000, 8);
    u_host.idle(20);
    settle();
    axi(1'b0, dsc_pkg::OFF_STATUS, 32'h0, 4'hf);
    check("aborted word", 32'(d[15:0]), 32'(w));
    print_verdict();
  end
endmodule : dsc_ctrl_bench

/* File: verification/dsc_host.sv */
// dsc_host: serial host model that shifts framed words into the block
module dsc_host (
  output logic shift_clk,
  output logic word_frame_n,
  output logic serial_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // link clock idles high; send runs it inside a frame, idle runs it with the frame high
  initial begin
    shift_clk = 1'b1;
    word_frame_n = 1'b1;
    serial_in = 1'b0;
  end

  // ----------------------------------------------------------------
  // frame transfer
  // ----------------------------------------------------------------
  // n bits msb first, one per 32 ns link cycle; n below 16 aborts the word
  task automatic send(input logic [15:0] w, input int n);
    #7;
    word_frame_n = 1'b0;
    #16;
    for (int i = 15; i > 15 - n; i--) begin
      shift_clk = 1'b1;
      serial_in = w[i];
      #16;
      shift_clk = 1'b0;
      #16;
    end
    shift_clk = 1'b1;
    #16;
    word_frame_n = 1'b1;
    serial_in = ~serial_in; // released line must not hold the last bit
    #64;
  endtask : send

  // free-running link clock with the frame high; the block must ignore it
  task automatic idle(input int n);
    serial_in = 1'b1;
    repeat (n) begin
      shift_clk = 1'b0;
      #16;
      shift_clk = 1'b1;
      #16;
    end
  endtask : idle
endmodule : dsc_host

/* File: verilog/dsc_ctrl.sv */
// dsc_ctrl: dds control front end with serial port, select pins and axi4-lite registers
//
// Contract
// - sample serial data on every falling serial clock edge during a word.
// - each transfer carries exactly one 16-bit word, one bit per clock.
// - frame strobe driven low starts a new word load.
// - accumulator adds the step from the frequency register currently selected.
// - frequency register chosen by select pin or by a control bit.
// - frequency select pin registered on rising master clock edges.
// - four phase offsets; selected one added to accumulator before lookup.
// - two control bits may choose the phase offset instead of pins.
// - phase select pins sampled on rising master clock edges.
// - output frequency is binary fraction of master clock; all on master clock.
// - 32-bit accumulator adds step each cycle, wrapping modulo two to 32.
// - 12-bit phase offsets added to accumulator most significant bits.
module dsc_ctrl #(
  parameter int PHASE_W = dsc_pkg::PHASE_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic shift_clk,
  input wire logic word_frame_n,
  input wire logic serial_in,
  input wire logic freq_reg_choose,
  input wire logic phase_reg_choose_lsb,
  input wire logic phase_reg_choose_msb,
  output logic [PHASE_W-1:0] phase_out,
  input wire logic [dsc_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [dsc_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int ACC_W = dsc_pkg::ACC_W;
  localparam int WORD_W = dsc_pkg::WORD_W;
  localparam int NUM_PHASE = dsc_pkg::NUM_PHASE;

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (PHASE_W < 1 || PHASE_W > 12) begin : g_bad_phase
    $error("dsc_ctrl phase width must lie between 1 and 12");
  end

  // ----------------------------------------------------------------
  // serial capture in the serial clock domain
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] word_bus;
  logic word_tgl;

  dsc_shifter #(
    .WORD_W(WORD_W)
  ) u_shifter (
    .shift_clk(shift_clk),
    .rst(rst),
    .word_frame_n(word_frame_n),
    .serial_in(serial_in),
    .word(word_bus),
    .word_tgl(word_tgl)
  );

  // ----------------------------------------------------------------
  // crossings into the master clock domain
  // ----------------------------------------------------------------
  logic tgl_s1;
  logic tgl_s2;
  logic tgl_s3;
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic word_new;

  // two flops on the toggle, a third to find its edge
  always_ff @(posedge clk) begin
    if (rst) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
    end else begin
      tgl_s1 <= word_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
    end
  end

  // select pins registered on rising master clock edges
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
    end else begin
      pin_s1 <= {phase_reg_choose_msb, phase_reg_choose_lsb, freq_reg_choose};
      pin_s2 <= pin_s1;
    end
  end

  // word is stable here: the next one needs sixteen more serial edges
  assign word_new = tgl_s2 ^ tgl_s3;

  // ----------------------------------------------------------------
  // serial command decode
  // ----------------------------------------------------------------
  logic [3:0] cmd;
  logic [2:0] byte_idx;
  logic ser_step_a;
  logic ser_step_b;
  logic ser_ctrl;
  logic [31:0] ser_mask;
  logic [31:0] ser_val;

  // command nibble, byte index and the lane it lands in
  assign cmd = word_bus[WORD_W-1:dsc_pkg::WORD_CMD_LSB];
  assign byte_idx = word_bus[dsc_pkg::WORD_IDX_LSB+2:dsc_pkg::WORD_IDX_LSB];
  assign ser_step_a = word_new && cmd == dsc_pkg::CMD_STEP_BYTE && !byte_idx[2];
  assign ser_step_b = word_new && cmd == dsc_pkg::CMD_STEP_BYTE && byte_idx[2];
  assign ser_ctrl = word_new && cmd == dsc_pkg::CMD_CTRL;
  assign ser_mask = 32'h0000_00ff << {byte_idx[1:0], 3'h0};
  assign ser_val = {24'h0, word_bus[7:0]} << {byte_idx[1:0], 3'h0};

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  logic aw_got;
  logic w_got;
  logic [dsc_pkg::AXI_AW-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic next_aw_got;
  logic next_w_got;
  logic next_bvalid;
  logic [31:0] strb_mask;
  logic wr_ctrl;
  logic wr_step_a;
  logic wr_step_b;
  logic [NUM_PHASE-1:0] wr_phase;
  logic wr_hit;

  // address and data are taken in either order, then written together
  assign wr_fire = aw_got && w_got && !s_axi_bvalid;
  assign next_aw_got = (aw_got || (s_axi_awvalid && s_axi_awready)) && !wr_fire;
  assign next_w_got = (w_got || (s_axi_wvalid && s_axi_wready)) && !wr_fire;
  assign next_bvalid = wr_fire || (s_axi_bvalid && !s_axi_bready);

  // write address decode
  assign wr_ctrl = wr_fire && aw_addr == dsc_pkg::OFF_CTRL;
  assign wr_step_a = wr_fire && aw_addr == dsc_pkg::OFF_STEP_A;
  assign wr_step_b = wr_fire && aw_addr == dsc_pkg::OFF_STEP_B;
  assign wr_hit = wr_ctrl || wr_step_a || wr_step_b || (|wr_phase) ||
                  aw_addr == dsc_pkg::OFF_STATUS || aw_addr == dsc_pkg::OFF_ACC;

  // byte lane mask from the write strobes
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign strb_mask[8*i +: 8] = {8{w_strb[i]}};
  end

  // capture of address, data and the response handshake
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dsc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bresp <= wr_hit ? dsc_pkg::RESP_OKAY : dsc_pkg::RESP_SLVERR;
      end
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      s_axi_bvalid <= next_bvalid;
      s_axi_awready <= !next_aw_got && !next_bvalid;
      s_axi_wready <= !next_w_got && !next_bvalid;
    end
  end

  // ----------------------------------------------------------------
  // control and frequency step registers
  // ----------------------------------------------------------------
  logic [dsc_pkg::CTRL_W-1:0] ctrl;
  logic [ACC_W-1:0] step_reg_a;
  logic [ACC_W-1:0] step_reg_b;
  logic [31:0] ctrl_wide;

  assign ctrl_wide = {28'h0, ctrl};

  // bus writes first, a serial word in the same cycle overrides them
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= dsc_pkg::CTRL_RESET;
      step_reg_a <= dsc_pkg::STEP_RESET;
      step_reg_b <= dsc_pkg::STEP_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl <= 4'((ctrl_wide & ~strb_mask) | (w_data & strb_mask));
      end
      if (wr_step_a) begin
        step_reg_a <= (step_reg_a & ~strb_mask) | (w_data & strb_mask);
      end
      if (wr_step_b) begin
        step_reg_b <= (step_reg_b & ~strb_mask) | (w_data & strb_mask);
      end
      if (ser_ctrl) begin
        ctrl <= word_bus[dsc_pkg::CTRL_W-1:0];
      end
      if (ser_step_a) begin
        step_reg_a <= (step_reg_a & ~ser_mask) | ser_val;
      end
      if (ser_step_b) begin
        step_reg_b <= (step_reg_b & ~ser_mask) | ser_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // phase offset registers, one per entry
  // ----------------------------------------------------------------
  logic [PHASE_W-1:0] phase_off [NUM_PHASE];

  for (genvar p = 0; p < NUM_PHASE; p++) begin : g_phase
    logic ser_hit;
    logic [31:0] old_wide;
    assign wr_phase[p] = wr_fire && aw_addr == 6'(dsc_pkg::OFF_PHASE0 + 4 * p);
    assign ser_hit = word_new && cmd == {dsc_pkg::CMD_PHASE_TOP, 2'(p)};
    assign old_wide = {{(32-PHASE_W){1'b0}}, phase_off[p]};

    // four offsets, each loaded from the bus or a serial word
    always_ff @(posedge clk) begin
      if (rst) begin
        phase_off[p] <= PHASE_W'(dsc_pkg::PHASE_RESET);
      end else if (ser_hit) begin
        phase_off[p] <= word_bus[PHASE_W-1:0];
      end else if (wr_phase[p]) begin
        phase_off[p] <= PHASE_W'((old_wide & ~strb_mask) | (w_data & strb_mask));
      end
    end
  end

  // ----------------------------------------------------------------
  // register selection and phase accumulator
  // ----------------------------------------------------------------
  logic use_bits;
  logic freq_sel;
  logic [1:0] phase_sel;
  logic [ACC_W-1:0] step_sel;
  logic [PHASE_W-1:0] offset_sel;
  logic [ACC_W-1:0] acc;
  logic [WORD_W-1:0] serial_word;

  // pins are ignored while the control bits choose, so they may sit low
  assign use_bits = ctrl[dsc_pkg::CTRL_USE_BITS];
  assign freq_sel = use_bits ? ctrl[dsc_pkg::CTRL_FREQ_BIT] : pin_s2[0];
  assign phase_sel = use_bits ? ctrl[dsc_pkg::CTRL_PHASE_LSB +: 2] : pin_s2[2:1];
  assign step_sel = freq_sel ? step_reg_b : step_reg_a;
  assign offset_sel = phase_off[phase_sel];

  // accumulator wraps naturally at its width, all on the master clock
  always_ff @(posedge clk) begin
    if (rst) begin
      acc <= '0;
      phase_out <= '0;
    end else begin
      acc <= acc + step_sel;
      phase_out <= acc[ACC_W-1 -: PHASE_W] + offset_sel;
    end
  end

  // last serial word kept for status reads
  always_ff @(posedge clk) begin
    if (rst) begin
      serial_word <= '0;
    end else if (word_new) begin
      serial_word <= word_bus;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  logic rd_take;
  logic next_rvalid;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic [1:0] rd_idx;
  logic rd_phase;

  // read address decode and data selection
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign next_rvalid = rd_take || (s_axi_rvalid && !s_axi_rready);
  assign rd_idx = 2'((s_axi_araddr - dsc_pkg::OFF_PHASE0) >> 2);
  assign rd_phase = s_axi_araddr >= dsc_pkg::OFF_PHASE0 &&
                    s_axi_araddr < dsc_pkg::OFF_STATUS && s_axi_araddr[1:0] == 2'h0;
  assign rd_hit = rd_phase || s_axi_araddr == dsc_pkg::OFF_CTRL ||
                  s_axi_araddr == dsc_pkg::OFF_STEP_A || s_axi_araddr == dsc_pkg::OFF_STEP_B ||
                  s_axi_araddr == dsc_pkg::OFF_STATUS || s_axi_araddr == dsc_pkg::OFF_ACC;
  assign rd_mux = rd_phase ? {{(32-PHASE_W){1'b0}}, phase_off[rd_idx]} :
                  s_axi_araddr == dsc_pkg::OFF_CTRL ? ctrl_wide :
                  s_axi_araddr == dsc_pkg::OFF_STEP_A ? step_reg_a :
                  s_axi_araddr == dsc_pkg::OFF_STEP_B ? step_reg_b :
                  s_axi_araddr == dsc_pkg::OFF_STATUS ?
                    {13'h0, freq_sel, phase_sel, serial_word} :
                  s_axi_araddr == dsc_pkg::OFF_ACC ? acc : 32'h0000_0000;

  // one read at a time, data registered with the response
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= dsc_pkg::RESP_OKAY;
    end else begin
      if (rd_take) begin
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? dsc_pkg::RESP_OKAY : dsc_pkg::RESP_SLVERR;
      end
      s_axi_rvalid <= next_rvalid;
      s_axi_arready <= !next_rvalid;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // pins held still long enough to pass both synchroniser flops
  sequence freq_pin_steady;
    (!use_bits && $stable(freq_reg_choose)) [*3];
  endsequence

  sequence phase_pin_steady;
    (!use_bits && $stable({phase_reg_choose_msb, phase_reg_choose_lsb})) [*3];
  endsequence

  sequence word_arrives;
    tgl_s2 != tgl_s3;
  endsequence

  a_acc_wrap: assert property (
    1'b1 |=> acc == ACC_W'($past(acc) + $past(step_sel)))
    else $error("accumulator did not add the selected step");

  a_freq_pin_path: assert property (
    freq_pin_steady |-> step_sel == (freq_reg_choose ? step_reg_b : step_reg_a))
    else $error("frequency pin did not pick the step register");

  a_phase_pin_path: assert property (
    phase_pin_steady |->
      offset_sel == phase_off[{phase_reg_choose_msb, phase_reg_choose_lsb}])
    else $error("phase pins did not pick the offset register");

  a_bit_select: assert property (
    use_bits |-> step_sel == (ctrl[dsc_pkg::CTRL_FREQ_BIT] ? step_reg_b : step_reg_a) &&
                 offset_sel == phase_off[ctrl[dsc_pkg::CTRL_PHASE_LSB +: 2]])
    else $error("control bits did not choose the registers");

  a_phase_sum: assert property (
    1'b1 |=> phase_out == PHASE_W'($past(acc[ACC_W-1 -: PHASE_W]) + $past(offset_sel)))
    else $error("phase offset not added to accumulator top bits");

  a_word_apply: assert property (
    word_arrives |=> serial_word == $past(word_bus))
    else $error("completed serial word not taken");

endmodule : dsc_ctrl

/* File: verilog/dsc_shifter.sv */
// dsc_shifter: serial word capture on the serial clock domain
module dsc_shifter #(
  parameter int WORD_W = dsc_pkg::WORD_W
) (
  input wire logic shift_clk,
  input wire logic rst,
  input wire logic word_frame_n,
  input wire logic serial_in,
  output logic [WORD_W-1:0] word,
  output logic word_tgl
);

  localparam int CNT_W = $clog2(WORD_W);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(WORD_W - 1);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (WORD_W < 2) begin : g_bad_width
    $error("dsc_shifter needs a word of at least two bits");
  end

  logic [CNT_W-1:0] cnt;
  logic [WORD_W-1:0] shreg;
  logic clr;
  logic [WORD_W-1:0] next_word;

  // a high frame or the system reset clears the bit counter at once
  assign clr = rst | word_frame_n;
  assign next_word = {shreg[WORD_W-2:0], serial_in};

  // bit counter; the serial clock may stop, so the frame itself clears it
  always_ff @(negedge shift_clk or posedge clr) begin
    if (clr) begin
      cnt <= '0;
    end else if (cnt == LAST) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  // data bits shift in on falling edges only inside a frame
  always_ff @(negedge shift_clk) begin
    if (!word_frame_n) begin
      shreg <= next_word;
    end
  end

  // a full word is held and announced by a toggle
  always_ff @(negedge shift_clk or posedge rst) begin
    if (rst) begin
      word <= '0;
      word_tgl <= 1'b0;
    end else if (!word_frame_n && cnt == LAST) begin
      word <= next_word;
      word_tgl <= ~word_tgl;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_bit_shift: assert property (@(negedge shift_clk) disable iff (clr)
    1'b1 |=> shreg[0] == $past(serial_in))
    else $error("serial bit not shifted in on falling edge");

  a_word_length: assert property (@(negedge shift_clk) disable iff (clr)
    cnt == LAST |=> cnt == '0 && word_tgl != $past(word_tgl))
    else $error("word not completed after sixteen bits");

  a_frame_start: assert property (@(negedge word_frame_n) disable iff (rst)
    1'b1 |-> cnt == '0)
    else $error("word load did not start at bit zero");

  a_idle_ignore: assert property (@(negedge shift_clk) disable iff (rst)
    word_frame_n |=> $stable(word_tgl))
    else $error("word announced while frame was high");

endmodule : dsc_shifter
